// File: verilog/aod_pkg.sv
// constants, types and the delay decoder for the audio output delay block
// assumes one 10 MHz clock; the control pins arrive unsynchronised
`default_nettype none

package aod_pkg;

  // ***************************************************************
  // control word addresses and field layout
  // ***************************************************************
  localparam logic [7:0] AOD_ADDR_SPDIF = 8'hec;
  localparam logic [7:0] AOD_ADDR_SERIAL = 8'hed;
  localparam int AOD_ADDR_BITS = 8;
  localparam int AOD_WORD_BITS = 16;
  localparam int AOD_HR_LSB = 8;
  localparam int AOD_TR_LSB = 13;
  localparam int AOD_S48_LSB = 0;
  localparam int AOD_S96_LSB = 8;

  // ***************************************************************
  // delay values in ms and the last linear code of each field
  // ***************************************************************
  localparam logic [8:0] AOD_MS_STEP = 9'h00a;
  localparam logic [8:0] AOD_MAX_882 = 9'h08b;
  localparam logic [8:0] AOD_MAX_96 = 9'h080;
  localparam logic [8:0] AOD_MAX_1764 = 9'h045;
  localparam logic [8:0] AOD_MAX_192 = 9'h040;
  localparam logic [8:0] AOD_MAX_S48 = 9'h100;
  localparam logic [8:0] AOD_MAX_S96 = 9'h080;
  localparam logic [4:0] AOD_HR_LAST = 5'h0c;
  localparam logic [4:0] AOD_TR_LAST = 5'h06;
  localparam logic [4:0] AOD_S48_LAST = 5'h19;
  localparam logic [4:0] AOD_S96_LAST = 5'h0c;

  // ***************************************************************
  // data path
  // ***************************************************************
  localparam int AOD_AUD_W = 24;
  localparam int AOD_FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    AOD_BAND_BASE = 2'b00,
    AOD_BAND_HIGH = 2'b01,
    AOD_BAND_TOP = 2'b10
  } aod_band_t;

  typedef enum logic [1:0] {
    AOD_PH_IDLE = 2'b00,
    AOD_PH_ADDR = 2'b01,
    AOD_PH_DATA = 2'b10
  } aod_phase_t;

  typedef struct packed {
    logic right;
    logic [AOD_AUD_W-1:0] sample;
  } aod_sample_t;

  typedef struct packed {
    logic sclk;
    logic en;
    logic sdata;
  } aod_pins_t;

  // zero is no delay, 1..last is 10 ms per count, last+1 is the maximum,
  // anything above is no delay again
  function automatic logic [8:0] aod_dly(input logic [4:0] code,
                                         input logic [4:0] last,
                                         input logic [8:0] maxv);
    logic [8:0] res;
    res = 9'h000;
    if (code != 5'h00 && code <= last) begin
      res = 9'(9'(code) * AOD_MS_STEP);
    end else if (code == 5'(last + 5'h01)) begin
      res = maxv;
    end
    return res;
  endfunction

endpackage

`default_nettype wire

// File: verilog/aod_fifo.sv
// sample fifo with valid/ready on both sides
// assumes both sides on clk; flip-flop storage addressed by index
`default_nettype none

module aod_fifo
  import aod_pkg::*;
#(
  parameter int W = 25,
  parameter int D = AOD_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
    logic vld;
  } aod_fifo_st_t;

  aod_fifo_st_t st_r, st_nxt;
  logic push, pop;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    st_nxt = st_r;
    push = in_valid & st_r.rdy;
    pop = st_r.vld & out_ready;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = (st_r.wp == AW'(D - 1)) ? '0 : AW'(st_r.wp + 1'b1);
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(D - 1)) ? '0 : AW'(st_r.rp + 1'b1);
    end
    st_nxt.cnt = (AW + 1)'(st_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop));
    st_nxt.rdy = st_nxt.cnt != (AW + 1)'(D);
    st_nxt.vld = st_nxt.cnt != '0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.rdy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready = st_r.rdy;
  assign out_valid = st_r.vld;
  assign out_data = st_r.mem[st_r.rp];

endmodule

`default_nettype wire

// File: verilog/aod_delay_cfg.sv
// delay configuration for the delayed audio output, written over the
// serial control port, plus the sample path through a 16 word fifo
// assumes clk at 10 MHz, pins asynchronous, band and source inputs
// coming from receiver logic on clk
//
// Notes on behaviour
// - high rate band: 0 none, 1..12 give ten ms per count
// - high rate code 13 gives 139 or 128 ms; 14, 15 none
// - top rate band: 0 none, 1..6 give ten ms per count
// - top rate code 7 gives 69 ms or 64 ms
// - serial input 48k: 0 none, 1..25 give ten ms per count
// - serial 48k code 26 gives 256 ms; 27..31 none
// - serial input 96k: 0 none, 1..12 give ten ms per count
// - serial 96k code 13 gives 128 ms; 14, 15 none
`default_nettype none

module aod_delay_cfg
  import aod_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ctl_sclk,
  input wire logic ctl_en,
  input wire logic ctl_sdata,
  input wire logic src_serial,
  input wire aod_band_t band,
  input wire logic fam_44k,
  input wire aod_sample_t in_sample,
  input wire logic in_valid,
  output logic in_ready,
  output aod_sample_t delayed_audio_out,
  output logic out_valid,
  input wire logic out_ready,
  output logic [8:0] delay_ms,
  output logic delay_active
);

  typedef struct packed {
    aod_pins_t sy1;
    aod_pins_t sy2;
    aod_pins_t sy3;
    aod_phase_t ph;
    logic [AOD_ADDR_BITS-1:0] addr;
    logic [AOD_WORD_BITS-1:0] word;
    logic [4:0] cnt;
    logic [3:0] high_rate_delay_code;
    logic [2:0] top_rate_delay_code;
    logic [4:0] serial_in_48k_delay_code;
    logic [3:0] serial_in_96k_delay_code;
    logic [8:0] dly;
    logic act;
    logic ovld;
    aod_sample_t odata;
    logic in_rdy;
  } aod_st_t;

  aod_st_t st_r, st_nxt;
  aod_sample_t fifo_data;
  logic fifo_vld, fifo_pop, fifo_rdy;
  logic sclk_rise, en_rise, en_fall;

  // ***************************************************************
  // sample fifo
  // ***************************************************************
  aod_fifo #(
    .W($bits(aod_sample_t)),
    .D(AOD_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(in_sample),
    .in_valid(in_valid),
    .in_ready(fifo_rdy),
    .out_data(fifo_data),
    .out_valid(fifo_vld),
    .out_ready(fifo_pop)
  );

  assign fifo_pop = fifo_vld & (~st_r.ovld | out_ready);

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.sy1 = '{sclk: ctl_sclk, en: ctl_en, sdata: ctl_sdata};
    st_nxt.sy2 = st_r.sy1;
    st_nxt.sy3 = st_r.sy2;
    sclk_rise = st_r.sy2.sclk & ~st_r.sy3.sclk;
    en_rise = st_r.sy2.en & ~st_r.sy3.en;
    en_fall = ~st_r.sy2.en & st_r.sy3.en;

    // serial control port: address while enable low, data while high
    case (st_r.ph)
      AOD_PH_ADDR: begin
        if (en_rise) begin
          st_nxt.cnt = 5'h00;
          st_nxt.word = '0;
          if (st_r.cnt == 5'(AOD_ADDR_BITS) &&
              (st_r.addr == AOD_ADDR_SPDIF ||
               st_r.addr == AOD_ADDR_SERIAL)) begin
            st_nxt.ph = AOD_PH_DATA;
          end else begin
            st_nxt.ph = AOD_PH_IDLE;
          end
        end else if (sclk_rise) begin
          st_nxt.addr = {st_r.sy2.sdata, st_r.addr[AOD_ADDR_BITS-1:1]};
          if (st_r.cnt != 5'h1f) begin
            st_nxt.cnt = 5'(st_r.cnt + 5'h01);
          end
        end
      end
      AOD_PH_DATA: begin
        if (en_fall) begin
          if (st_r.cnt == 5'(AOD_WORD_BITS)) begin
            if (st_r.addr == AOD_ADDR_SPDIF) begin
              // only the field bits are taken
              st_nxt.high_rate_delay_code = st_r.word[AOD_HR_LSB +: 4];
              st_nxt.top_rate_delay_code = st_r.word[AOD_TR_LSB +: 3];
            end else begin
              st_nxt.serial_in_48k_delay_code =
                st_r.word[AOD_S48_LSB +: 5];
              st_nxt.serial_in_96k_delay_code =
                st_r.word[AOD_S96_LSB +: 4];
            end
          end
          st_nxt.ph = AOD_PH_ADDR;
          st_nxt.cnt = 5'h00;
          st_nxt.addr = '0;
        end else if (sclk_rise) begin
          st_nxt.word = {st_r.sy2.sdata, st_r.word[AOD_WORD_BITS-1:1]};
          if (st_r.cnt <= 5'(AOD_WORD_BITS)) begin
            st_nxt.cnt = 5'(st_r.cnt + 5'h01);
          end
        end
      end
      AOD_PH_IDLE: begin
        if (en_fall) begin
          st_nxt.ph = AOD_PH_ADDR;
          st_nxt.cnt = 5'h00;
          st_nxt.addr = '0;
        end
      end
      default: begin
        st_nxt.ph = AOD_PH_ADDR;
      end
    endcase

    // delay selection for the current source and rate band
    st_nxt.dly = 9'h000;
    if (src_serial) begin
      if (band == AOD_BAND_BASE) begin
        st_nxt.dly = aod_dly(st_r.serial_in_48k_delay_code,
                             AOD_S48_LAST, AOD_MAX_S48);
      end else if (band == AOD_BAND_HIGH) begin
        st_nxt.dly = aod_dly(5'(st_r.serial_in_96k_delay_code),
                             AOD_S96_LAST, AOD_MAX_S96);
      end
    end else if (band == AOD_BAND_HIGH) begin
      st_nxt.dly = aod_dly(5'(st_r.high_rate_delay_code), AOD_HR_LAST,
                           fam_44k ? AOD_MAX_882 : AOD_MAX_96);
    end else if (band == AOD_BAND_TOP) begin
      st_nxt.dly = aod_dly(5'(st_r.top_rate_delay_code), AOD_TR_LAST,
                           fam_44k ? AOD_MAX_1764 : AOD_MAX_192);
    end
    st_nxt.act = st_nxt.dly != 9'h000;

    // output register stage
    if (fifo_pop) begin
      st_nxt.ovld = 1'b1;
      st_nxt.odata = fifo_data;
    end else if (out_ready) begin
      st_nxt.ovld = 1'b0;
    end
    st_nxt.in_rdy = fifo_rdy;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.ph <= AOD_PH_ADDR;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign delay_ms = st_r.dly;
  assign delay_active = st_r.act;
  assign out_valid = st_r.ovld;
  assign delayed_audio_out = st_r.odata;
  assign in_ready = st_r.in_rdy;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_hr_linear: assert property (
    (!src_serial && band == AOD_BAND_HIGH &&
     st_r.high_rate_delay_code inside {[4'h1:4'hc]}) |=>
    delay_ms == 9'(9'($past(st_r.high_rate_delay_code)) * AOD_MS_STEP))
    else $error("high rate linear delay wrong");
  a_hr_max: assert property (
    (!src_serial && band == AOD_BAND_HIGH &&
     st_r.high_rate_delay_code == 4'hd) |=>
    delay_ms == ($past(fam_44k) ? AOD_MAX_882 : AOD_MAX_96))
    else $error("high rate maximum delay wrong");
  a_hr_none: assert property (
    (!src_serial && band == AOD_BAND_HIGH &&
     st_r.high_rate_delay_code inside {4'h0, 4'he, 4'hf}) |=>
    (delay_ms == 9'h000 && !delay_active))
    else $error("high rate code should give no delay");
  a_tr_linear: assert property (
    (!src_serial && band == AOD_BAND_TOP &&
     st_r.top_rate_delay_code != 3'h7) |=>
    delay_ms == 9'(9'($past(st_r.top_rate_delay_code)) * AOD_MS_STEP))
    else $error("top rate linear delay wrong");
  a_tr_max: assert property (
    (!src_serial && band == AOD_BAND_TOP &&
     st_r.top_rate_delay_code == 3'h7) |=>
    delay_ms == ($past(fam_44k) ? AOD_MAX_1764 : AOD_MAX_192))
    else $error("top rate maximum delay wrong");
  a_s48_linear: assert property (
    (src_serial && band == AOD_BAND_BASE &&
     st_r.serial_in_48k_delay_code <= 5'h19) |=> delay_ms ==
    9'(9'($past(st_r.serial_in_48k_delay_code)) * AOD_MS_STEP))
    else $error("serial 48k linear delay wrong");
  a_s48_max: assert property (
    (src_serial && band == AOD_BAND_BASE &&
     st_r.serial_in_48k_delay_code >= 5'h1a) |=> delay_ms ==
    (($past(st_r.serial_in_48k_delay_code) == 5'h1a) ?
     AOD_MAX_S48 : 9'h000))
    else $error("serial 48k top codes wrong");
  a_s96_linear: assert property (
    (src_serial && band == AOD_BAND_HIGH &&
     st_r.serial_in_96k_delay_code <= 4'hc) |=> delay_ms ==
    9'(9'($past(st_r.serial_in_96k_delay_code)) * AOD_MS_STEP))
    else $error("serial 96k linear delay wrong");
  a_s96_max: assert property (
    (src_serial && band == AOD_BAND_HIGH &&
     st_r.serial_in_96k_delay_code >= 4'hd) |=> delay_ms ==
    (($past(st_r.serial_in_96k_delay_code) == 4'hd) ?
     AOD_MAX_S96 : 9'h000))
    else $error("serial 96k top codes wrong");
  a_reset_codes: assert property (
    $past(rst) |->
    (st_r.high_rate_delay_code == 4'h0 && st_r.top_rate_delay_code == 3'h0
     && st_r.serial_in_48k_delay_code == 5'h00 &&
     st_r.serial_in_96k_delay_code == 4'h0))
    else $error("delay codes not zero after reset");

  c_serial_write: cover property (st_r.ph == AOD_PH_DATA && en_fall &&
      st_r.cnt == 5'(AOD_WORD_BITS) && st_r.addr == AOD_ADDR_SERIAL);
  c_max_s48: cover property (delay_ms == AOD_MAX_S48);
  c_fifo_full: cover property (in_valid && !in_ready);
  c_hr_max: cover property (delay_ms == AOD_MAX_882);

endmodule

`default_nettype wire

// File: test/aod_host_model.sv
// host side of the serial control port: writes one control word
// assumes clk is the design clock; pins change only after clk rises
`default_nettype none

module aod_host_model
  import aod_pkg::*;
(
  input wire logic clk,
  output logic ctl_sclk,
  output logic ctl_en,
  output logic ctl_sdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    ctl_sclk = 1'b0;
    ctl_en = 1'b0;
    ctl_sdata = 1'b0;
  end

  // every pin level stands at least four clocks
  task automatic hold4();
    repeat (4) @(posedge clk);
  endtask

  task automatic send_bit(input logic b);
    ctl_sdata <= b;
    hold4();
    ctl_sclk <= 1'b1;
    hold4();
    ctl_sclk <= 1'b0;
  endtask

  // ***************************************************************
  // one write: address with enable low, data with enable high
  // ***************************************************************
  task automatic write_word(input logic [7:0] addr,
                            input logic [15:0] data,
                            input logic dirty);
    logic [15:0] mask;
    logic [15:0] w;
    mask = (addr == AOD_ADDR_SPDIF) ? 16'hef1f : 16'h0f1f;
    w = dirty ? (data | ~mask) : (data & mask);
    @(posedge clk);
    for (int i = 0; i < 8; i++) send_bit(addr[i]);
    hold4();
    ctl_en <= 1'b1;
    hold4();
    for (int i = 0; i < 16; i++) send_bit(w[i]);
    hold4();
    ctl_en <= 1'b0;
    // idle data line shows no stale bit
    ctl_sdata <= ~w[15];
    hold4();
  endtask
endmodule

`default_nettype wire

// File: test/tb_top.sv
// bench for the audio output delay block: control writes, delay
// selection against an integer model, and the sample fifo
// assumes the host model drives the control pins
`default_nettype none

module tb_top
  import aod_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic src_serial = 1'b0;
  aod_band_t band = AOD_BAND_BASE;
  logic fam_44k = 1'b0;
  aod_sample_t in_sample = '0;
  logic in_valid = 1'b0;
  logic out_ready = 1'b0;
  logic in_ready;
  aod_sample_t delayed_audio_out;
  logic out_valid;
  logic [8:0] delay_ms;
  logic delay_active;
  logic ctl_sclk;
  logic ctl_en;
  logic ctl_sdata;
  int failures = 0;
  int n_compared = 0;
  int m_hr = 0;
  int m_tr = 0;
  int m_s48 = 0;
  int m_s96 = 0;
  logic [31:0] seed = 32'h3c24e8ff;
  aod_sample_t q[$];

  initial begin
    forever #50 clk = ~clk;
  end

  aod_host_model aod_host_model_i (
    .clk(clk),
    .ctl_sclk(ctl_sclk),
    .ctl_en(ctl_en),
    .ctl_sdata(ctl_sdata)
  );

  aod_delay_cfg aod_delay_cfg_i (
    .clk(clk),
    .rst(rst),
    .ctl_sclk(ctl_sclk),
    .ctl_en(ctl_en),
    .ctl_sdata(ctl_sdata),
    .src_serial(src_serial),
    .band(band),
    .fam_44k(fam_44k),
    .in_sample(in_sample),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .delayed_audio_out(delayed_audio_out),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .delay_ms(delay_ms),
    .delay_active(delay_active)
  );

  // ***************************************************************
  // helpers and reference model
  // ***************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic int code_ms(int code, int last, int maxv);
    if (code >= 1 && code <= last) return code * 10;
    if (code == last + 1) return maxv;
    return 0;
  endfunction

  function automatic int exp_ms();
    if (src_serial) begin
      if (band == AOD_BAND_BASE) return code_ms(m_s48, 25, 256);
      if (band == AOD_BAND_HIGH) return code_ms(m_s96, 12, 128);
      return 0;
    end
    if (band == AOD_BAND_HIGH) return code_ms(m_hr, 12, fam_44k ? 139 : 128);
    if (band == AOD_BAND_TOP) return code_ms(m_tr, 6, fam_44k ? 69 : 64);
    return 0;
  endfunction

  task automatic look(input logic s, input aod_band_t b, input logic f);
    int e;
    @(posedge clk);
    src_serial <= s;
    band <= b;
    fam_44k <= f;
    repeat (3) @(posedge clk);
    @(negedge clk);
    e = exp_ms();
    check(delay_ms, e);
    check(delay_active, e != 0);
  endtask

  task automatic look_all();
    look(1'b0, AOD_BAND_HIGH, 1'b0);
    look(1'b0, AOD_BAND_HIGH, 1'b1);
    look(1'b0, AOD_BAND_TOP, 1'b0);
    look(1'b0, AOD_BAND_TOP, 1'b1);
    look(1'b1, AOD_BAND_BASE, 1'(rnd()));
    look(1'b1, AOD_BAND_HIGH, 1'(rnd()));
  endtask

  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    aod_sample_t s;
    int taken;
    taken = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    look_all();
    for (int i = 0; i < 16; i++) begin
      m_hr = i;
      m_tr = i % 8;
      aod_host_model_i.write_word(AOD_ADDR_SPDIF,
        16'((m_tr << 13) | (m_hr << 8)), 1'b0);
      look_all();
    end
    for (int i = 0; i < 32; i++) begin
      m_s48 = i;
      m_s96 = (i + 5) % 16;
      aod_host_model_i.write_word(AOD_ADDR_SERIAL,
        16'((m_s96 << 8) | m_s48), 1'b0);
      look_all();
    end
    // unused bits set must not change the selection
    m_s48 = 26;
    m_s96 = 13;
    aod_host_model_i.write_word(AOD_ADDR_SERIAL, 16'h0d1a, 1'b1);
    look_all();
    // unknown address leaves every code alone
    aod_host_model_i.write_word(8'hee, 16'h0000, 1'b0);
    look_all();
    // a second reset brings every code back to its default
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    m_hr = 0;
    m_tr = 0;
    m_s48 = 0;
    m_s96 = 0;
    look_all();
    // fill the fifo with the far side stalled
    for (int k = 0; k < 40; k++) begin
      @(negedge clk);
      if (in_ready !== 1'b1) break;
      @(posedge clk);
      s = aod_sample_t'(25'(rnd()));
      in_sample <= s;
      in_valid <= 1'b1;
      @(posedge clk);
      in_valid <= 1'b0;
      q.push_back(s);
      taken++;
      @(posedge clk);
    end
    // the output stage holds one word on top of the full fifo
    check(taken, AOD_FIFO_DEPTH + 1);
    // drain with random stalls, order must hold
    for (int k = 0; k < 400 && q.size() > 0; k++) begin
      @(negedge clk);
      if (out_valid === 1'b1 && out_ready === 1'b1)
        check(delayed_audio_out, q.pop_front());
      @(posedge clk);
      out_ready <= 1'(rnd());
    end
    check(q.size(), 32'h0);
    @(negedge clk);
    check(out_valid, 1'b0);
    stop_test();
  end

  initial begin
    #3000000;
    failures++;
    stop_test();
  end
endmodule

`default_nettype wire
